// File: rtl/bus_err_pkg.sv
// Shared constants and carrier types for the bus error logger
`default_nettype none
package bus_err_pkg;

  // ----------------------------------------------------------------
  // Masters
  // ----------------------------------------------------------------
  localparam int          NUM_MASTERS = 6;
  localparam logic [2:0]  M_IFETCH    = 3'h0;
  localparam logic [2:0]  M_CPU_DATA  = 3'h1;
  localparam logic [2:0]  M_EXT_MSTR  = 3'h2;
  localparam logic [2:0]  M_PCI       = 3'h3;
  localparam logic [2:0]  M_MEDIA     = 3'h4;
  localparam logic [2:0]  M_DMA       = 3'h5;

  // ----------------------------------------------------------------
  // Error type codes, other codes reserved
  // ----------------------------------------------------------------
  localparam logic [2:0]  ET_NONE     = 3'h0;
  localparam logic [2:0]  ET_PARITY   = 3'h1;
  localparam logic [2:0]  ET_PROTECT  = 3'h4;
  localparam logic [2:0]  ET_EXT_IN   = 3'h6;
  localparam logic [2:0]  ET_TIMEOUT  = 3'h7;

  // ----------------------------------------------------------------
  // Field positions, msb-zero bit k sits at vector bit 31-k
  // ----------------------------------------------------------------
  localparam int TYPE_LSB [NUM_MASTERS] = '{29, 23, 17, 11, 29, 23};
  localparam int DIR_POS  [NUM_MASTERS] = '{28, 22, 16, 10, 28, 22};
  localparam int FL_POS   [NUM_MASTERS] = '{0, 0, 0, 9, 27, 21};
  localparam int AL_POS   [NUM_MASTERS] = '{0, 0, 0, 8, 26, 20};
  localparam logic [NUM_MASTERS-1:0] LOCK_MASK  = 6'h38;
  localparam logic [NUM_MASTERS-1:0] STAT1_MASK = 6'h30;
  localparam logic [31:0] TYPE_ONES   = 32'h0000_0007;
  localparam logic [31:0] BIT_ONE     = 32'h0000_0001;
  localparam logic [31:0] STAT1_RSVD  = 32'h000f_ffff;

  // ----------------------------------------------------------------
  // Indirect access
  // ----------------------------------------------------------------
  localparam int          IDX_W       = 8;
  localparam logic [IDX_W-1:0] IDX_ERR_ADDR = 8'h00;
  localparam logic [IDX_W-1:0] IDX_STAT0    = 8'h01;
  localparam logic [IDX_W-1:0] IDX_STAT1    = 8'h02;
  localparam logic        SEL_INDEX   = 1'b0;
  localparam logic        SEL_DATA    = 1'b1;

  // Register move request from the processor
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        sel;
    logic [31:0] wdata;
  } dcr_req_s;

  // Error event from the detectors
  typedef struct packed {
    logic       valid;
    logic [2:0] master;
    logic [2:0] etype;
    logic       read;
    logic       lock_req;
  } err_evt_s;

endpackage
`default_nettype wire

// File: rtl/bus_error_logger.sv
// Error address capture and per-master error status log
//
// Overview of operation
// (R1) Capture 32-bit address of failing access
// (R2) Locked error freezes address until unlock
// (R3) Access only via index and data registers
// (R4) Address taken from bus in parity cycle
// (R5) Software uses hold time for exact address
// (R6) Status split over two registers by master
// (R7) Masters numbered fetch, data, ext, pci, mal, dma
// (R8) Three-bit error type code per master
// (R9) Direction bit one for read, zero write
// (R10) First register field positions per master
// (R11) Pci master field and address lock bits
// (R12) Second register layout, upper bits reserved
// (R13) Locked field ignores later errors
// (R14) Parity after bus error logged unless locking
// (R15) Only one master may lock address
// (R16) Software clears status and locks together
// (R17) Reset and software writes clear fields
`timescale 1ns/1ps
`default_nettype none
module bus_error_logger (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  // Register move port
  input  wire bus_err_pkg::dcr_req_s dcr_req_i,
  output logic [31:0]                dcr_rdata_o,
  output logic                       dcr_ack_o,
  // Error events and current bus address
  input  wire bus_err_pkg::err_evt_s err_evt_i,
  input  wire logic [31:0]           bus_addr_i
);

  localparam int NM = bus_err_pkg::NUM_MASTERS;

  typedef struct packed {
    logic [bus_err_pkg::IDX_W-1:0] index;
    logic [31:0]                   err_addr;
    logic [NM-1:0]                 alock;
    logic [31:0]                   rdata;
    logic                          ack;
    logic                          prev_err;
    logic [2:0]                    prev_master;
  } log_state_s;

  log_state_s q, d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Bits of a master's status field that a write may clear
  function automatic logic [31:0] field_mask(input int i);
    logic [31:0] m;
    m = (bus_err_pkg::TYPE_ONES << bus_err_pkg::TYPE_LSB[i])
      | (bus_err_pkg::BIT_ONE << bus_err_pkg::DIR_POS[i]);
    if (bus_err_pkg::LOCK_MASK[i]) begin
      m = m | (bus_err_pkg::BIT_ONE << bus_err_pkg::FL_POS[i]);
    end
    return m;
  endfunction

  // Index of the status register that holds a master
  function automatic logic [bus_err_pkg::IDX_W-1:0] stat_idx(input int i);
    return bus_err_pkg::STAT1_MASK[i] ? bus_err_pkg::IDX_STAT1 : bus_err_pkg::IDX_STAT0;
  endfunction

  // ----------------------------------------------------------------
  // Per-master field slots
  // ----------------------------------------------------------------
  logic [NM-1:0] log_vec;
  logic [NM-1:0] clr_vec;
  logic [NM-1:0] flock_w;
  logic [NM-1:0] read_w;
  logic [2:0]    etype_w [NM];

  for (genvar g = 0; g < NM; g++) begin : g_slot
    err_field_slot #(
      .HAS_LOCK (bus_err_pkg::LOCK_MASK[g])
    ) u_slot (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .log_i     (log_vec[g]),
      .etype_i   (err_evt_i.etype),
      .read_i    (err_evt_i.read),
      .lock_i    (err_evt_i.lock_req),
      .clr_i     (clr_vec[g]),
      .etype_o   (etype_w[g]),
      .read_o    (read_w[g]),
      .flock_o   (flock_w[g])
    );
  end

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  logic          evt_ok;
  logic          follow_on;
  logic          eff_lock;
  logic          fld_hit;
  logic          addr_upd;
  logic [NM-1:0] al_set;

  // Master ids above the last one are dropped
  always_comb begin
    // (R7) valid master numbers only
    evt_ok    = err_evt_i.valid && (err_evt_i.master < 3'(NM));
    // (R14) parity right behind a bus error of the same master
    follow_on = evt_ok && (err_evt_i.etype == bus_err_pkg::ET_PARITY)
              && q.prev_err && (q.prev_master == err_evt_i.master);
    eff_lock  = evt_ok && err_evt_i.lock_req
              && bus_err_pkg::LOCK_MASK[err_evt_i.master];
    // (R13) locked fields drop later errors
    fld_hit   = evt_ok && !flock_w[err_evt_i.master]
              && !(follow_on && err_evt_i.lock_req);
    // (R2) address frozen while any lock stands
    addr_upd  = evt_ok && !follow_on && (q.alock == '0);
    // (R15) first locker alone owns the address
    al_set    = '0;
    if (fld_hit && eff_lock && !follow_on && (q.alock == '0)) begin
      al_set[err_evt_i.master] = 1'b1;
    end
    log_vec   = '0;
    if (fld_hit) begin
      // (R6) event routed to its master's field
      log_vec[err_evt_i.master] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Software clears through the data register
  // ----------------------------------------------------------------
  logic          data_wr;
  logic [NM-1:0] al_clr;

  // A one written over any type, direction or field lock bit clears that field
  always_comb begin
    data_wr = dcr_req_i.wr && (dcr_req_i.sel == bus_err_pkg::SEL_DATA);
    clr_vec = '0;
    al_clr  = '0;
    for (int i = 0; i < NM; i++) begin
      if (data_wr && (q.index == stat_idx(i))) begin
        // (R17) write-one clear of status and locks
        clr_vec[i] = |(dcr_req_i.wdata & field_mask(i));
        al_clr[i]  = bus_err_pkg::LOCK_MASK[i]
                   && dcr_req_i.wdata[bus_err_pkg::AL_POS[i]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status register images
  // ----------------------------------------------------------------
  logic [31:0] stat0;
  logic [31:0] stat1;
  logic [31:0] fld;

  // Reserved bits stay zero since only field bits are ored in
  always_comb begin
    stat0 = '0;
    stat1 = '0;
    fld   = '0;
    for (int i = 0; i < NM; i++) begin
      // (R8) three-bit type code at its position
      fld = (32'(etype_w[i]) << bus_err_pkg::TYPE_LSB[i])
          | (32'(read_w[i]) << bus_err_pkg::DIR_POS[i]);
      if (bus_err_pkg::LOCK_MASK[i]) begin
        // (R11) field and address lock bits
        fld = fld | (32'(flock_w[i]) << bus_err_pkg::FL_POS[i])
                  | (32'(q.alock[i]) << bus_err_pkg::AL_POS[i]);
      end
      if (bus_err_pkg::STAT1_MASK[i]) begin
        // (R12) media and dma in second register
        stat1 = stat1 | fld;
      end else begin
        // (R10) cpu, external and pci in first register
        stat0 = stat0 | fld;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // (R3) indirect index written through the index register
    if (dcr_req_i.wr && (dcr_req_i.sel == bus_err_pkg::SEL_INDEX)) begin
      d.index = dcr_req_i.wdata[bus_err_pkg::IDX_W-1:0];
    end
    // (R3) reads answer one cycle later
    d.ack   = dcr_req_i.rd || dcr_req_i.wr;
    d.rdata = '0;
    if (dcr_req_i.rd) begin
      if (dcr_req_i.sel == bus_err_pkg::SEL_INDEX) begin
        d.rdata = 32'(q.index);
      end else begin
        case (q.index)
          bus_err_pkg::IDX_ERR_ADDR: d.rdata = q.err_addr;
          bus_err_pkg::IDX_STAT0:    d.rdata = stat0;
          bus_err_pkg::IDX_STAT1:    d.rdata = stat1;
          default:                   d.rdata = '0;
        endcase
      end
    end
    // (R1) address of the failing access captured
    // (R4) a lone parity error takes the address seen now, a parity follow-on keeps the held one
    if (addr_upd) begin
      d.err_addr = bus_addr_i;
    end
    // (R15) a new lock needs all locks free before this edge, a same-cycle clear comes too late
    d.alock       = (q.alock & ~al_clr) | al_set;
    d.prev_err    = evt_ok && (err_evt_i.etype != bus_err_pkg::ET_PARITY);
    d.prev_master = err_evt_i.master;
  end

  // Registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dcr_rdata_o = q.rdata;
  assign dcr_ack_o   = q.ack;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_addr_capture: assert property ( // (R4)
    evt_ok && !follow_on && (q.alock == '0) |=> q.err_addr == $past(bus_addr_i))
    else $error("error address not captured");

  chk_addr_frozen: assert property ( // (R2)
    (q.alock != '0) && (al_clr == '0) |=> $stable(q.err_addr) && (q.alock != '0))
    else $error("locked address changed");

  chk_single_locker: assert property ( // (R15)
    $onehot0(q.alock))
    else $error("more than one address lock");

  chk_ack_one_cycle: assert property ( // (R3)
    (dcr_req_i.rd || dcr_req_i.wr) |=> dcr_ack_o ##1 !dcr_ack_o || $past(dcr_req_i.rd || dcr_req_i.wr))
    else $error("ack timing wrong");

  chk_index_write: assert property ( // (R3)
    dcr_req_i.wr && (dcr_req_i.sel == bus_err_pkg::SEL_INDEX)
    |=> q.index == $past(dcr_req_i.wdata[bus_err_pkg::IDX_W-1:0]))
    else $error("index not written");

  chk_stat1_reserved: assert property ( // (R12)
    dcr_req_i.rd && (dcr_req_i.sel == bus_err_pkg::SEL_DATA) && (q.index == bus_err_pkg::IDX_STAT1)
    |=> (dcr_rdata_o & bus_err_pkg::STAT1_RSVD) == '0)
    else $error("reserved bits set");

  chk_follow_keeps_addr: assert property ( // (R14)
    follow_on |=> $stable(q.err_addr))
    else $error("parity follow-on moved address");

  chk_lock_on_error: assert property ( // (R15)
    fld_hit && eff_lock && !follow_on && (q.alock == '0)
    |=> q.alock[$past(err_evt_i.master)] && flock_w[$past(err_evt_i.master)])
    else $error("lock bits not set");

  cov_addr_locked:  cover property (al_set != '0 ##1 q.alock != '0);
  cov_parity_after: cover property (follow_on);
  cov_stat0_read:   cover property (dcr_req_i.rd && (q.index == bus_err_pkg::IDX_STAT0));
  cov_unlock:       cover property ((q.alock != '0) ##1 (q.alock == '0));

endmodule
`default_nettype wire

// File: rtl/err_field_slot.sv
// One master's error type, direction and field lock
`timescale 1ns/1ps
`default_nettype none
module err_field_slot #(
  parameter bit HAS_LOCK = 1'b0
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Log request, already gated by the owner
  input  wire logic       log_i,
  input  wire logic [2:0] etype_i,
  input  wire logic       read_i,
  input  wire logic       lock_i,
  // Software clear
  input  wire logic       clr_i,
  // Stored fields
  output logic [2:0]      etype_o,
  output logic            read_o,
  output logic            flock_o
);

  typedef struct packed {
    logic [2:0] etype;
    logic       read;
    logic       flock;
  } slot_s;

  slot_s q, d;

  // ----------------------------------------------------------------
  // Next state, a new error beats a clear in the same cycle unless the field was locked
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (clr_i) begin
      // (R17) software clear
      d = '0;
    end
    if (log_i && !q.flock) begin
      // (R9) type and direction stored
      d.etype = etype_i;
      d.read  = read_i;
      d.flock = HAS_LOCK && lock_i;
    end
  end

  // Registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign etype_o = q.etype;
  assign read_o  = q.read;
  assign flock_o = q.flock;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_lock_holds_fields: assert property ( // (R13)
    q.flock && !clr_i |=> $stable(q.etype) && $stable(q.read) && q.flock)
    else $error("locked field changed");

  chk_log_stores_fields: assert property ( // (R9)
    log_i && !q.flock |=> q.etype == $past(etype_i) && q.read == $past(read_i))
    else $error("error not stored");

  cov_field_locked: cover property (log_i && lock_i && HAS_LOCK ##1 q.flock);

endmodule
`default_nettype wire

// File: sim/err_source.sv
// Behavioural source of bus error events and the external address
`timescale 1ns/1ps
`default_nettype none
module err_source (
  // Clock
  input  wire logic             mclk_i,
  // Event and address towards the logger
  output bus_err_pkg::err_evt_s err_evt_o,
  output logic [31:0]           bus_addr_o
);
  // Nine event bits stacked on the 32-bit address
  logic [40:0] q [$];
  logic [40:0] item;

  initial begin
    err_evt_o  = '0;
    bus_addr_o = 32'h0000_0000;
  end

  // One queued event per cycle; between events the
  // address is inverted so a stale capture shows up
  always @(posedge mclk_i) begin
    #1;
    if (q.size() > 0) begin
      item = q.pop_front();
      {err_evt_o, bus_addr_o} = item;
    end else begin
      err_evt_o  = {1'b0, err_evt_o[7:0] ^ 8'hff};
      bus_addr_o = ~bus_addr_o;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the bus error logger
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk;
  logic                  rst;
  bus_err_pkg::dcr_req_s req;
  bus_err_pkg::err_evt_s evt;
  bus_err_pkg::err_evt_s pv;
  logic [31:0]           rdata;
  logic                  ack;
  logic [31:0]           addr;
  logic [31:0]           addr_m;
  logic [31:0]           rd_v;
  logic [7:0]            idx;
  logic [2:0]            typ [6];
  logic                  dr [6];
  logic                  fl [6];
  logic                  al [6];
  logic                  ack_e;
  logic                  rd_e;
  int                    failures;
  int                    tests_run;

  bus_error_logger DUT (
    .mclk_i     (clk),
    .sys_rst_i  (rst),
    .dcr_req_i  (req),
    .dcr_rdata_o(rdata),
    .dcr_ack_o  (ack),
    .err_evt_i  (evt),
    .bus_addr_i (addr)
  );
  err_source src (
    .mclk_i    (clk),
    .err_evt_o (evt),
    .bus_addr_o(addr)
  );

  // ----------------------------------------
  // Clock, compare and verdict
  // ----------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Status word from model fields, positions worked out per master
  function automatic logic [31:0] stat(input int r);
    logic [31:0] v;
    int          t;
    v = 32'h0000_0000;
    for (int m = 0; m < 6; m++) begin
      t = 29 - 6 * (m % 4);
      if ((m > 3) == (r == 2)) begin
        v[t+:3] = typ[m];
        v[t-1]  = dr[m];
        if (m > 2) begin
          v[t-2] = fl[m];
          v[t-3] = al[m];
        end
      end
    end
    return v;
  endfunction

  // ----------------------------------------
  // Reference model, read value taken before this edge's updates
  // ----------------------------------------
  // logging and locking
  always @(posedge clk) begin
    int   t;
    logic fo;
    logic anyal;
    logic flk;
    if (rst) begin
      for (int m = 0; m < 6; m++) begin
        {typ[m], dr[m], fl[m], al[m]} = '0;
      end
      {addr_m, idx, pv, ack_e, rd_e} = '0;
    end else begin
      check({31'h0, ack}, {31'h0, ack_e});
      // Read data stands in the ack cycle of a read only, zero otherwise
      check(rdata, (ack_e && rd_e) ? rd_v : 32'h0);
      ack_e = req.rd | req.wr;
      rd_e  = req.rd;
      rd_v  = req.sel ? (idx == 8'h00 ? addr_m : idx < 8'h03 ? stat(idx) : 32'h0) : {24'h0, idx};
      // Locks as they stood before this edge, a same-cycle clear comes too late
      anyal = al[3] | al[4] | al[5];
      flk   = (evt.master < 3'h6) ? fl[evt.master] : 1'b0;
      if (req.wr && !req.sel) idx = req.wdata[7:0];
      if (req.wr && req.sel && (idx == 8'h01 || idx == 8'h02)) begin
        for (int m = 0; m < 6; m++) begin
          t = 29 - 6 * (m % 4);
          if ((m > 3) == (idx == 8'h02)) begin
            if (|req.wdata[t-1+:4] || (m > 2 && req.wdata[t-2])) {typ[m], dr[m], fl[m]} = '0;
            if (m > 2 && req.wdata[t-3]) al[m] = 1'b0;
          end
        end
      end
      if (evt.valid && evt.master < 3'h6) begin
        fo    = pv.valid && pv.master == evt.master && pv.etype != 3'h1 && evt.etype == 3'h1;
        if (!fo && !anyal) addr_m = addr;
        if (!(fo && evt.lock_req) && !flk) begin
          typ[evt.master] = evt.etype;
          dr[evt.master]  = evt.read;
          if (evt.lock_req && evt.master > 3'h2) begin
            fl[evt.master] = 1'b1;
            al[evt.master] = al[evt.master] | !anyal;
          end
        end
      end
      pv = evt;
    end
  end

  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  // one register move, pulse held a full cycle
  task automatic acc(input logic w, input logic s, input logic [31:0] d);
    @(posedge clk);
    #1;
    req = {~w, w, s, d};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  task automatic rdi(input int i);
    acc(1'b1, 1'b0, 32'(i));
    acc(1'b0, 1'b1, 32'h0);
  endtask

  task automatic ev(input int m, input int t, input logic r, input logic l, input logic [31:0] a);
    src.q.push_back({1'b1, 3'(m), 3'(t), r, l, a});
  endtask

  task automatic drain;
    for (int i = 0; i < 64 && src.q.size() > 0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // fields and both locks cleared, one write per status register
  task automatic clear_all;
    for (int r = 1; r < 3; r++) begin
      acc(1'b1, 1'b0, 32'(r));
      acc(1'b1, 1'b1, 32'hffff_ffff);
    end
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #(25 * 20000);
    failures++;
    test_done;
  end

  initial begin
    logic [31:0] a;
    int          codes [4];
    codes = '{1, 4, 6, 7};
    rst   = 1'b1;
    req   = '0;
    void'($urandom(92));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 3; i++) rdi(i);
    acc(1'b0, 1'b0, 32'h0);
    for (int m = 0; m < 6; m++) begin
      foreach (codes[c]) begin
        ev(m, codes[c], codes[c][0], 1'b0, $urandom);
        drain;
        rdi(m > 3 ? 2 : 1);
        rdi(0);
      end
    end
    clear_all;
    // first locking master owns the address
    ev(3, 4, 1'b1, 1'b1, 32'h1000_0040);
    ev(4, 6, 1'b0, 1'b1, 32'h2000_0080);
    ev(3, 7, 1'b0, 1'b0, 32'h3000_00c0);
    drain;
    for (int i = 0; i < 3; i++) rdi(i);
    clear_all;
    ev(2, 1, 1'b1, 1'b0, 32'h4000_0100);
    drain;
    rdi(0);
    // address index refuses writes, unmapped index reads zero
    acc(1'b1, 1'b0, 32'h0);
    acc(1'b1, 1'b1, 32'hffff_ffff);
    rdi(0);
    acc(1'b1, 1'b0, 32'h7);
    acc(1'b1, 1'b1, 32'hffff_ffff);
    rdi(7);
    // parity follow-on, address held over the hold cycle
    a = $urandom;
    ev(1, 4, 1'b1, 1'b0, a);
    ev(1, 1, 1'b0, 1'b0, a);
    ev(5, 7, 1'b1, 1'b0, a + 4);
    ev(5, 1, 1'b0, 1'b1, a + 4);
    drain;
    for (int i = 0; i < 3; i++) rdi(i);
    // Random bursts, full readback, periodic clears
    for (int k = 0; k < 40; k++) begin
      for (int j = 0; j < 8; j++) begin
        ev($urandom % 8, codes[$urandom % 4], 1'($urandom), 1'($urandom), $urandom);
      end
      drain;
      for (int i = 0; i < 3; i++) rdi(i);
      if (k % 3 == 2) clear_all;
    end
    // reset in mid-run wipes logged state
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 3; i++) rdi(i);
    repeat (2) @(posedge clk);
    test_done;
  end
endmodule
`default_nettype wire
